/* File: design/cais_pkg.sv */
package cais_pkg;

    // register offsets inside the bus-master i/o window
    localparam logic [7:0] CAIS_OFS_ACCESS_LOCK = 8'h34;
    localparam logic [7:0] CAIS_OFS_STEERING_MAP = 8'h80;

    // reset values
    localparam logic [7:0] CAIS_RST_ACCESS_LOCK = 8'h00;
    localparam logic [7:0] CAIS_RST_STEERING_MAP = 8'h00;

    // field positions of codec_access_lock
    localparam int CAIS_LOCK_FLAG_BIT = 0;

    // field positions of input_line_steering_map
    localparam int CAIS_SEL2_MSB = 7;
    localparam int CAIS_SEL2_LSB = 6;
    localparam int CAIS_SEL1_MSB = 5;
    localparam int CAIS_SEL1_LSB = 4;
    localparam int CAIS_STEER_ON_BIT = 3;
    localparam int CAIS_MAP_RSVD_BIT = 2;
    localparam int CAIS_LAST_SRC_MSB = 1;
    localparam int CAIS_LAST_SRC_LSB = 0;

    // line select codes
    localparam logic [1:0] CAIS_LINE_0 = 2'h0;
    localparam logic [1:0] CAIS_LINE_1 = 2'h1;
    localparam logic [1:0] CAIS_LINE_2 = 2'h2;
    localparam logic [1:0] CAIS_LINE_RSVD = 2'h3;

    // documented number of codec serial input lines
    localparam int CAIS_NUM_LINES = 3;

    // semaphore state
    typedef enum logic [0:0] {
        CAIS_LOCK_FREE,
        CAIS_LOCK_OWNED
    } cais_lock_state_t;

endpackage

/* File: design/cais_steer_if.sv */
`timescale 1ns/100ps
interface cais_steer_if #(
    parameter int NUM_LINES = 3
);
    logic steer_on;
    logic [1:0] first_select;
    logic [1:0] second_select;
    logic [NUM_LINES-1:0] lines;
    logic first_data;
    logic second_data;

    modport ctrl (
        output steer_on,
        output first_select,
        output second_select,
        output lines,
        input first_data,
        input second_data
    );

    modport mux (
        input steer_on,
        input first_select,
        input second_select,
        input lines,
        output first_data,
        output second_data
    );
endinterface

/* File: design/cais_line_steer.sv */
`timescale 1ns/100ps
module cais_line_steer
    import cais_pkg::*;
#(
    parameter int NUM_LINES = 3
)
(
    cais_steer_if.mux steer
);

    ////////////////////////////////////////////////////////////////////////
    // per-line select match; a reserved code matches no line
    logic [NUM_LINES-1:0] pick_first;
    logic [NUM_LINES-1:0] pick_second;
    logic or_all;

    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++)
        begin : g_line
            assign pick_first[g] = steer.lines[g] && (steer.first_select == 2'(g)); // [R09]
            assign pick_second[g] = steer.lines[g] && (steer.second_select == 2'(g)); // [R08]
        end
    endgenerate

    assign or_all = |steer.lines; // [R07]

    ////////////////////////////////////////////////////////////////////////
    // steering off: first path gets the or, second path is idle
    assign steer.first_data = steer.steer_on ? (|pick_first) : or_all; // [R06] [R10]
    assign steer.second_data = steer.steer_on ? (|pick_second) : 1'b0; // [R07] [R08]

endmodule

/* File: design/cais_core.sv */
`timescale 1ns/100ps
// Functional notes
// (R01) semaphore read returns flag, then sets it
// (R02) hardware clears flag when access completes; a lock read in the same cycle keeps it set
// (R03) flag zero when idle; bits 7:1 reserved
// (R04) driver reads semaphore before codec access
// (R05) semaphore at 34h, 8 bits, reset 00h
// (R06) steering on keeps input lines separate
// (R07) steering off ORs lines; second engines off
// (R08) bits 7:6 pick second path line
// (R09) bits 5:4 pick first path line
// (R10) steering off: first path uses OR
// (R11) bits 1:0 record last read line
// (R12) steering map at 80h, reset 00h, bit2 reserved
// (R13) read while owned returns 1, stays set
module cais_core
    import cais_pkg::*;
#(
    parameter int NUM_LINES = CAIS_NUM_LINES
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // bus-master i/o window access
    input wire logic [7:0] io_offset,
    input wire logic io_read,
    input wire logic io_write,
    input wire logic [7:0] io_write_data,
    output logic [7:0] io_read_data,
    output logic io_read_valid,
    // codec register access engine
    input wire logic codec_access_done,
    input wire logic codec_read_done,
    input wire logic [1:0] codec_read_line,
    // codec serial input lines, one sampled bit per line
    input wire logic [NUM_LINES-1:0] codec_serial_input,
    // dma engine slot data
    output logic first_input_data,
    output logic second_input_data,
    output logic second_engines_available
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration check: two-bit select codes reach lines 0 to 2 only
    generate
        if (NUM_LINES < 1 || NUM_LINES > CAIS_NUM_LINES)
        begin : g_bad_lines
            $error("cais_core: NUM_LINES must lie between 1 and 3");
        end
        // the read view packs the map fields side by side
        if (CAIS_SEL2_LSB != CAIS_SEL1_MSB + 1 || CAIS_SEL1_LSB != CAIS_STEER_ON_BIT + 1)
        begin : g_bad_fields
            $error("cais_core: steering map fields must be adjacent");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic hit_lock;
    logic hit_map;
    logic lock_read;
    logic map_write;

    assign hit_lock = (io_offset == CAIS_OFS_ACCESS_LOCK); // [R05]
    assign hit_map = (io_offset == CAIS_OFS_STEERING_MAP); // [R12]
    assign lock_read = io_read && hit_lock;
    assign map_write = io_write && hit_map;

    ////////////////////////////////////////////////////////////////////////
    // codec access semaphore
    cais_lock_state_t lock_state;
    cais_lock_state_t next_lock_state;
    logic lock_flag;

    assign lock_flag = (lock_state == CAIS_LOCK_OWNED);

    // a read in the same cycle as completion re-arms the flag:
    // the new reader still reads 1, and the flag stays set past the old access
    always_comb
    begin
        next_lock_state = lock_state;
        case (lock_state)
            CAIS_LOCK_FREE:
            begin
                if (lock_read)
                begin
                    next_lock_state = CAIS_LOCK_OWNED; // [R01]
                end
            end
            CAIS_LOCK_OWNED:
            begin
                if (lock_read)
                begin
                    next_lock_state = CAIS_LOCK_OWNED; // [R13]
                end
                else if (codec_access_done)
                begin
                    next_lock_state = CAIS_LOCK_FREE; // [R02] [R03]
                end
            end
            default:
            begin
                next_lock_state = CAIS_LOCK_FREE;
            end
        endcase
    end

    // reset leaves the lock free, matching the 00h value
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lock_state <= CAIS_LOCK_FREE; // [R05]
        end
        else
        begin
            lock_state <= next_lock_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // steering map writable fields
    logic line_steering_on;
    logic [1:0] first_input_line_select;
    logic [1:0] second_input_line_select;

    // steering enable; it also gates the second engines
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            line_steering_on <= CAIS_RST_STEERING_MAP[CAIS_STEER_ON_BIT]; // [R12]
        end
        else if (map_write)
        begin
            line_steering_on <= io_write_data[CAIS_STEER_ON_BIT]; // [R06]
        end
    end

    // select fields are stored even while steering is off; they are ignored
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            first_input_line_select <= CAIS_RST_STEERING_MAP[CAIS_SEL1_MSB:CAIS_SEL1_LSB];
        end
        else if (map_write)
        begin
            first_input_line_select <= io_write_data[CAIS_SEL1_MSB:CAIS_SEL1_LSB]; // [R09]
        end
    end

    // second path select, live only with steering on
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            second_input_line_select <= CAIS_RST_STEERING_MAP[CAIS_SEL2_MSB:CAIS_SEL2_LSB];
        end
        else if (map_write)
        begin
            second_input_line_select <= io_write_data[CAIS_SEL2_MSB:CAIS_SEL2_LSB]; // [R08]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // last read source line, read-only to software
    logic [1:0] last_read_source_line;

    // a reserved line code from the engine is kept as given
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            last_read_source_line <= CAIS_RST_STEERING_MAP[CAIS_LAST_SRC_MSB:CAIS_LAST_SRC_LSB];
        end
        else if (codec_read_done)
        begin
            last_read_source_line <= codec_read_line; // [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read data; pre-read flag value is returned
    logic [7:0] lock_view;
    logic [7:0] map_view;
    logic [7:0] next_read_data;

    // reserved lock bits tie low
    always_comb
    begin
        lock_view = 8'h00; // [R03]
        lock_view[CAIS_LOCK_FLAG_BIT] = lock_flag; // [R01] [R13]
    end

    // bit 2 has no storage, it is wired low
    always_comb
    begin
        map_view = 8'h00;
        map_view[CAIS_SEL2_MSB:CAIS_SEL2_LSB] = second_input_line_select;
        map_view[CAIS_SEL1_MSB:CAIS_SEL1_LSB] = first_input_line_select;
        map_view[CAIS_STEER_ON_BIT] = line_steering_on;
        map_view[CAIS_MAP_RSVD_BIT] = 1'b0; // [R12]
        map_view[CAIS_LAST_SRC_MSB:CAIS_LAST_SRC_LSB] = last_read_source_line; // [R11]
    end

    // unmapped offsets read as zero
    always_comb
    begin
        case (io_offset)
            CAIS_OFS_ACCESS_LOCK:
            begin
                next_read_data = lock_view; // [R05]
            end
            CAIS_OFS_STEERING_MAP:
            begin
                next_read_data = map_view; // [R12]
            end
            default:
            begin
                next_read_data = 8'h00;
            end
        endcase
    end

    // answer strobe, one cycle after each read
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            io_read_valid <= 1'b0;
        end
        else
        begin
            io_read_valid <= io_read;
        end
    end

    // data holds until the next read so a slow master can still pick it up
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            io_read_data <= 8'h00;
        end
        else if (io_read)
        begin
            io_read_data <= next_read_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input line steering
    cais_steer_if #(.NUM_LINES(NUM_LINES)) steer ();

    assign steer.steer_on = line_steering_on;
    assign steer.first_select = first_input_line_select;
    assign steer.second_select = second_input_line_select;
    assign steer.lines = codec_serial_input;

    cais_line_steer #(
        .NUM_LINES(NUM_LINES)
    ) u_line_steer (
        .steer(steer.mux)
    );

    // slot data registered once so the engines see clean levels
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            first_input_data <= 1'b0;
        end
        else
        begin
            first_input_data <= steer.first_data; // [R06] [R10]
        end
    end

    // idles low while steering is off
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            second_input_data <= 1'b0;
        end
        else
        begin
            second_input_data <= steer.second_data; // [R08]
        end
    end

    // lags the enable by one cycle, in step with the data paths
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            second_engines_available <= 1'b0;
        end
        else
        begin
            second_engines_available <= line_steering_on; // [R07]
        end
    end

endmodule

/* File: verification/cais_core_monitor.sv */
`timescale 1ns/100ps
module cais_core_monitor #(
    parameter int NUM_LINES = 3
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register window
    input wire logic [7:0] io_offset,
    input wire logic io_read,
    input wire logic io_write,
    input wire logic [7:0] io_write_data,
    input wire logic [7:0] io_read_data,
    input wire logic io_read_valid,
    // codec engine
    input wire logic codec_access_done,
    input wire logic codec_read_done,
    input wire logic [1:0] codec_read_line,
    // serial lines and dma paths
    input wire logic [NUM_LINES-1:0] codec_serial_input,
    input wire logic first_input_data,
    input wire logic second_input_data,
    input wire logic second_engines_available
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    sequence s_lock_rd;
        io_read && io_offset == 8'h34;
    endsequence
    sequence s_freed;
        codec_access_done && !io_read ##1 s_lock_rd;
    endsequence
    property p_rd_valid; io_read |=> io_read_valid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("no read answer");
    property p_owned; s_lock_rd ##1 s_lock_rd |=> io_read_data == 8'h01; endproperty
    a_owned: assert property (p_owned) else $error("second reader not refused");
    property p_freed; s_freed |=> io_read_data == 8'h00; endproperty
    a_freed: assert property (p_freed) else $error("lock not freed");
    property p_lock_rsvd; io_read_valid && $past(io_offset) == 8'h34 |-> io_read_data[7:1] == 7'h00; endproperty
    a_lock_rsvd: assert property (p_lock_rsvd) else $error("lock upper bits set");
    property p_last; codec_read_done ##1 io_read && io_offset == 8'h80 && !codec_read_done
        |=> io_read_data[1:0] == $past(codec_read_line, 2); endproperty
    a_last: assert property (p_last) else $error("last line wrong");
    property p_steer; io_write && io_offset == 8'h80 |=> ##1 second_engines_available == $past(io_write_data[3], 2);
    endproperty
    a_steer: assert property (p_steer) else $error("steer enable wrong");
    property p_second_off; !second_engines_available |-> !second_input_data; endproperty
    a_second_off: assert property (p_second_off) else $error("second path live");
    // only checked once the output was computed out of reset
    property p_or; $past(reset_n) && !second_engines_available |-> first_input_data == |$past(codec_serial_input);
    endproperty
    a_or: assert property (p_or) else $error("first path not ored");
endmodule

/* File: verification/cais_codec_model.sv */
`timescale 1ns/100ps
module cais_codec_model #(
    parameter int NUM_LINES = 3
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // wanted levels, one per codec
    input wire logic [NUM_LINES-1:0] line_pattern,
    // serial input lines
    output logic [NUM_LINES-1:0] codec_serial_input
);
    // codecs launch a cycle after the request, like a real slot bit
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            codec_serial_input <= '0;
        else
            codec_serial_input <= line_pattern;
    end
endmodule

/* File: verification/tb_codec_access_and_input_steering.sv */
`timescale 1ns/100ps
bind cais_core cais_core_monitor #(.NUM_LINES(NUM_LINES)) u_mon (.clk_sys(clk_sys), .reset_n(reset_n),
    .io_offset(io_offset), .io_read(io_read), .io_write(io_write), .io_write_data(io_write_data),
    .io_read_data(io_read_data), .io_read_valid(io_read_valid), .codec_access_done(codec_access_done),
    .codec_read_done(codec_read_done), .codec_read_line(codec_read_line), .codec_serial_input(codec_serial_input),
    .first_input_data(first_input_data), .second_input_data(second_input_data),
    .second_engines_available(second_engines_available));
module tb_codec_access_and_input_steering;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] io_offset = 8'h00;
    logic [7:0] io_write_data = 8'h00;
    logic io_read = 1'b0;
    logic io_write = 1'b0;
    logic codec_access_done = 1'b0;
    logic codec_read_done = 1'b0;
    logic [1:0] codec_read_line = 2'h0;
    logic [2:0] line_pattern = 3'h0;
    logic [2:0] codec_serial_input;
    logic [7:0] io_read_data;
    logic [7:0] rd_data;
    logic io_read_valid, first_input_data, second_input_data, second_engines_available;
    int num_errors = 0;
    int checks = 0;
    initial forever #10 clk_sys = ~clk_sys;
    cais_core u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .io_offset(io_offset), .io_read(io_read),
        .io_write(io_write), .io_write_data(io_write_data), .io_read_data(io_read_data),
        .io_read_valid(io_read_valid), .codec_access_done(codec_access_done), .codec_read_done(codec_read_done),
        .codec_read_line(codec_read_line), .codec_serial_input(codec_serial_input),
        .first_input_data(first_input_data), .second_input_data(second_input_data),
        .second_engines_available(second_engines_available));
    cais_codec_model u_codec (.clk_sys(clk_sys), .reset_n(reset_n), .line_pattern(line_pattern),
        .codec_serial_input(codec_serial_input));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // tasks start and end on a rising edge
    task automatic rd(input logic [7:0] ofs);
        io_offset <= ofs;
        io_read <= 1'b1;
        @(posedge clk_sys);
        io_read <= 1'b0;
        #1;
        rd_data = io_read_data;
        chk("read_valid", 8'h01, {7'h0, io_read_valid});
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        io_offset <= ofs;
        io_write_data <= d;
        io_write <= 1'b1;
        @(posedge clk_sys);
        io_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    // ends on the edge so a read can follow back to back
    task automatic pulse_done(input logic is_read, input logic [1:0] line);
        codec_access_done <= !is_read;
        codec_read_done <= is_read;
        codec_read_line <= line;
        @(posedge clk_sys);
        codec_access_done <= 1'b0;
        codec_read_done <= 1'b0;
    endtask
    task automatic check_lines(input logic on, input logic [1:0] s1, input logic [1:0] s2);
        logic [2:0] p;
        logic e1, e2;
        wr(8'h80, {s2, s1, on, 3'h7});
        rd(8'h80);
        chk("map", {s2, s1, on, 3'h2}, rd_data);
        for (int i = 1; i < 8; i++)
        begin
            p = i[2:0];
            e1 = !on ? |p : (s1 == 2'h3 ? 1'b0 : p[s1]);
            e2 = !on ? 1'b0 : (s2 == 2'h3 ? 1'b0 : p[s2]);
            line_pattern <= p;
            repeat (2) @(posedge clk_sys);
            #1;
            chk("first", {7'h0, e1}, {7'h0, first_input_data});
            chk("second", {7'h0, e2}, {7'h0, second_input_data});
            chk("avail", {7'h0, on}, {7'h0, second_engines_available});
            @(posedge clk_sys);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic test_reset;
        rd(8'h34);
        chk("lock", 8'h00, rd_data);
        rd(8'h80);
        chk("map", 8'h00, rd_data);
        rd(8'h40);
        chk("unmapped", 8'h00, rd_data);
        $display("test_reset done");
    endtask
    task automatic test_lock;
        pulse_done(1'b0, 2'h0);
        io_offset <= 8'h34;
        io_read <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("lock_first", 8'h00, io_read_data);
        @(posedge clk_sys);
        io_read <= 1'b0;
        #1;
        chk("lock_second", 8'h01, io_read_data);
        @(posedge clk_sys);
        wr(8'h34, 8'hff);
        rd(8'h34);
        chk("lock_held", 8'h01, rd_data);
        pulse_done(1'b0, 2'h0);
        rd(8'h34);
        chk("lock_freed", 8'h00, rd_data);
        io_offset <= 8'h34;
        io_read <= 1'b1;
        codec_access_done <= 1'b1;
        @(posedge clk_sys);
        io_read <= 1'b0;
        codec_access_done <= 1'b0;
        #1;
        chk("lock_collide_rd", 8'h01, io_read_data);
        @(posedge clk_sys);
        rd(8'h34);
        chk("lock_collide", 8'h01, rd_data);
        $display("test_lock done");
    endtask
    task automatic test_last;
        for (int i = 0; i < 3; i++)
        begin
            pulse_done(1'b1, i[1:0]);
            rd(8'h80);
            chk("last_line", {6'h0, i[1:0]}, rd_data);
        end
        wr(8'h80, 8'h07);
        rd(8'h80);
        chk("map_ro", 8'h02, rd_data);
        $display("test_last done");
    endtask
    task automatic test_steer;
        check_lines(1'b0, 2'h1, 2'h3);
        for (int s = 0; s < 4; s++)
            check_lines(1'b1, s[1:0], 2'h3 - s[1:0]);
        $display("test_steer done");
    endtask
    task automatic complete_run;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        test_reset;
        test_lock;
        test_last;
        test_steer;
        complete_run;
    end
    // the tests take some 165 cycles, so this leaves wide margin
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        complete_run;
    end
endmodule
